// *** src/pin_select_pkg.sv ***
// Constants shared by the pin function selection logic.
// Assumes a single 40 MHz clock and a synchronous active-low reset.
package pin_select_pkg;

  // ****************************************************************
  // Pin position masks
  // ****************************************************************
  // Timer/interrupt port pins that carry a timer flip-flop output.
  localparam logic [7:0] TIMER_OUT_MASK   = 8'h64;
  // Timer/interrupt port pins that carry a capture or interrupt input.
  localparam logic [7:0] TIMER_IN_MASK    = 8'h1b;
  // Serial port pins (0..5) that carry a transmit or clock output.
  localparam logic [5:0] UART_OUT_MASK    = 6'h2d;
  // Serial-bus port pins that carry serial-bus unit outputs.
  localparam logic [7:0] SBUS_OUT_MASK    = 8'he0;

  // ****************************************************************
  // Reset values and strap encodings
  // ****************************************************************
  // Open-drain select field after reset: both pins push-pull.
  localparam logic [1:0] OD_SEL_RESET     = 2'h0;
  // Strap level meaning a 16-bit or mixed bus with muxed upper byte.
  localparam logic       STRAP_MUX16      = 1'h0;
  // Value of all registered pin outputs during reset.
  localparam logic [7:0] PIN_RESET        = 8'h00;

endpackage : pin_select_pkg

// *** src/port_pin_function_select.sv ***
// Pin function selection for the timer/interrupt, serial/oscillator and
// serial-bus ports, plus the fixed external bus pins.
// Assumes configuration bits arrive as steady levels synchronous to clk,
// and that pads resolve each pin from its out/oe pair.
//
// Behaviour
// - function 0 selects plain input or output
// - oscillator pins output when direction is 1
// - oscillator pin outputs are open-drain only
// - low interrupt pins deliver requests when input
// - serial-bus data pin outputs when both bits 1
// - select field picks push-pull or open-drain
// - serial-bus outputs push-pull after reset
// - strobe, indicator, chip selects pull up when released
// - low bus pins multiplex address and data 0-7
// - strap 0: upper byte muxes address and data
// - strap 1: upper byte carries address only
// - top eight bus pins output address unless bus released
module port_pin_function_select
  import pin_select_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Timer/interrupt port configuration and pads.
  input  wire logic [7:0]  port8_direction_reg,
  input  wire logic [7:0]  port8_function_reg,
  input  wire logic [7:0]  port8_output_latch,
  input  wire logic [7:0]  port8_pin_in,
  output logic      [7:0]  port8_pin_out,
  output logic      [7:0]  port8_pin_oe,
  output logic      [7:0]  port8_read,
  // Timer peripheral side: outputs on pins 2, 5, 6.
  input  wire logic [2:0]  timer_flipflop_output,
  output logic      [3:0]  timer_capture_input,
  output logic      [3:0]  external_interrupt_input,
  // Serial/oscillator port configuration and pads.
  input  wire logic [7:0]  port9_direction_reg,
  input  wire logic [5:0]  port9_function_reg,
  input  wire logic [7:0]  port9_output_latch,
  input  wire logic [7:0]  port9_pin_in,
  output logic      [7:0]  port9_pin_out,
  output logic      [7:0]  port9_pin_oe,
  output logic      [7:0]  port9_read,
  // Two UART channels.
  input  wire logic [1:0]  uart_transmit_pin,
  input  wire logic [1:0]  uart_clock_pin,
  output logic      [1:0]  uart_receive_pin,
  output logic      [1:0]  uart_clear_to_send_pin,
  // Serial-bus port configuration and pads.
  input  wire logic [7:0]  porta_direction_reg,
  input  wire logic [7:0]  porta_function_reg,
  input  wire logic [7:0]  porta_output_latch,
  input  wire logic [7:0]  porta_pin_in,
  output logic      [7:0]  porta_pin_out,
  output logic      [7:0]  porta_pin_oe,
  output logic      [7:0]  porta_read,
  output logic      [3:0]  porta_interrupt_req,
  // Serial-bus unit: clock, data and clock-line outputs and inputs.
  input  wire logic        sbus_sck_out,
  input  wire logic        sbus_data_out,
  input  wire logic        sbus_scl_out,
  output logic             sbus_sck_in,
  output logic             sbus_data_in,
  output logic             sbus_scl_in,
  // Open-drain select field load port.
  input  wire logic        open_drain_select_load,
  input  wire logic [1:0]  open_drain_select_field,
  output logic      [1:0]  open_drain_enable_reg,
  // Pullup control for write strobe, read/write and chip selects.
  input  wire logic        strobe_function_bit,
  input  wire logic        rw_function_bit,
  input  wire logic [3:0]  cs_function_bits,
  input  wire logic        bus_released,
  output logic             high_byte_write_strobe_pullup,
  output logic             rw_indicator_pullup,
  output logic      [3:0]  chip_select_pullup,
  // External bus.
  input  wire logic        bus_width_strap_pin,
  input  wire logic        bus_addr_phase,
  input  wire logic        bus_data_drive,
  input  wire logic [23:0] bus_address,
  input  wire logic [15:0] bus_write_data,
  input  wire logic [15:0] bus_pin_in,
  output logic      [15:0] bus_read_data,
  output logic      [23:0] bus_pin_out,
  output logic      [23:0] bus_pin_oe
);

  // ****************************************************************
  // Combinational pin selection
  // ****************************************************************
  logic [7:0]  p8_alt;     // Timer outputs placed at their pin positions.
  logic [7:0]  p8_out;     // Value selected for each timer-port pin.
  logic [5:0]  p9_alt;     // UART outputs placed at their pin positions.
  logic [7:0]  p9_out;     // Value selected for each serial-port pin.
  logic [7:0]  p9_oe;      // Drive enable for each serial-port pin.
  logic [7:0]  pa_alt;     // Serial-bus outputs at their pin positions.
  logic [7:0]  pa_val;     // Logic value wanted on each serial-bus pin.
  logic [7:0]  pa_od;      // Pins currently in open-drain drive.
  logic        strap_r;    // Bus width strap caught during reset.
  logic [1:0]  od_sel_r;   // Open-drain select field.

  assign p8_alt = {1'b0, timer_flipflop_output[2:1], 2'b00,
                   timer_flipflop_output[0], 2'b00};
  assign p9_alt = {uart_clock_pin[1], 1'b0, uart_transmit_pin[1],
                   uart_clock_pin[0], 1'b0, uart_transmit_pin[0]};
  assign pa_alt = {sbus_scl_out, sbus_data_out, sbus_sck_out, 5'b00000};

  // Each pin takes its peripheral output only when both bits are set;
  // the output latch never takes part in that choice.
  always_comb begin
    p8_out = port8_output_latch;
    p8_out = p8_out & ~(port8_function_reg & TIMER_OUT_MASK);
    p8_out = p8_out | (p8_alt & port8_function_reg & TIMER_OUT_MASK);
    p9_out = port9_output_latch;
    p9_out[5:0] = (port9_output_latch[5:0] & ~(port9_function_reg
                  & UART_OUT_MASK))
                | (p9_alt & port9_function_reg & UART_OUT_MASK);
    // Oscillator pins never drive high: out stays low, oe pulls low.
    p9_out[7:6] = 2'b00;
    p9_oe = port9_direction_reg;
    p9_oe[7:6] = port9_direction_reg[7:6]
               & ~port9_output_latch[7:6];
    pa_val = (porta_output_latch & ~(porta_function_reg & SBUS_OUT_MASK))
           | (pa_alt & porta_function_reg & SBUS_OUT_MASK);
    pa_od = {od_sel_r, 6'b000000}
          & porta_function_reg & porta_direction_reg;
  end

  // ****************************************************************
  // Captured configuration
  // ****************************************************************
  // The strap is sampled while reset is held, so a strap that settles
  // late after power-up is still seen before the first bus cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_r <= bus_width_strap_pin;
    end
  end

  // Open-drain select field, push-pull out of reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      od_sel_r <= OD_SEL_RESET;
    end else if (open_drain_select_load) begin
      od_sel_r <= open_drain_select_field;
    end
  end
  assign open_drain_enable_reg = od_sel_r;

  // ****************************************************************
  // Registered pad outputs
  // ****************************************************************
  // All pad drives are registered so they change glitch-free.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port8_pin_out <= PIN_RESET;
      port8_pin_oe  <= PIN_RESET;
      port9_pin_out <= PIN_RESET;
      port9_pin_oe  <= PIN_RESET;
      porta_pin_out <= PIN_RESET;
      porta_pin_oe  <= PIN_RESET;
    end else begin
      port8_pin_out <= p8_out;
      port8_pin_oe  <= port8_direction_reg;
      port9_pin_out <= p9_out;
      port9_pin_oe  <= p9_oe;
      // An open-drain pin only drives when the wanted value is low.
      porta_pin_out <= pa_val & ~pa_od;
      porta_pin_oe  <= porta_direction_reg & ~(pa_od & pa_val);
    end
  end

  // ****************************************************************
  // Registered peripheral inputs and port reads
  // ****************************************************************
  // Interrupt inputs need only direction 0; capture and clear-to-send
  // inputs also need the function bit so a stray edge cannot count.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer_capture_input      <= 4'h0;
      external_interrupt_input <= 4'h0;
      uart_receive_pin         <= 2'h0;
      uart_clear_to_send_pin   <= 2'h0;
      porta_interrupt_req      <= 4'h0;
      sbus_sck_in              <= 1'h0;
      sbus_data_in             <= 1'h0;
      sbus_scl_in              <= 1'h0;
      port8_read               <= PIN_RESET;
      port9_read               <= PIN_RESET;
      porta_read               <= PIN_RESET;
    end else begin
      timer_capture_input <= {port8_pin_in[4:3], port8_pin_in[1:0]}
        & ~{port8_direction_reg[4:3], port8_direction_reg[1:0]}
        & {port8_function_reg[4:3], port8_function_reg[1:0]};
      external_interrupt_input <= {port8_pin_in[4:3], port8_pin_in[1:0]}
        & ~{port8_direction_reg[4:3], port8_direction_reg[1:0]};
      uart_receive_pin <= {port9_pin_in[4], port9_pin_in[1]}
        & ~{port9_direction_reg[4], port9_direction_reg[1]};
      uart_clear_to_send_pin <= {port9_pin_in[5], port9_pin_in[2]}
        & ~{port9_direction_reg[5], port9_direction_reg[2]}
        & {port9_function_reg[5], port9_function_reg[2]};
      porta_interrupt_req <= porta_pin_in[3:0]
                           & ~porta_direction_reg[3:0];
      sbus_sck_in  <= porta_pin_in[5] & ~porta_direction_reg[5]
                    & porta_function_reg[5];
      sbus_data_in <= porta_pin_in[6] & ~porta_direction_reg[6];
      sbus_scl_in  <= porta_pin_in[7] & ~porta_direction_reg[7];
      port8_read   <= port8_pin_in;
      port9_read   <= port9_pin_in;
      porta_read   <= porta_pin_in;
    end
  end

  // ****************************************************************
  // Bus control pullups
  // ****************************************************************
  // Pullups hold released control lines inactive while another master
  // owns the bus.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      high_byte_write_strobe_pullup <= 1'h0;
      rw_indicator_pullup           <= 1'h0;
      chip_select_pullup            <= 4'h0;
    end else begin
      high_byte_write_strobe_pullup <= strobe_function_bit
                                     & bus_released;
      rw_indicator_pullup <= rw_function_bit & bus_released;
      chip_select_pullup  <= cs_function_bits
                           & {4{bus_released}};
    end
  end

  // ****************************************************************
  // External bus pins
  // ****************************************************************
  // Address drives in the address phase; data drives only on writes.
  // All bus pins float while the bus is released.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_pin_out   <= 24'h000000;
      bus_pin_oe    <= 24'h000000;
      bus_read_data <= 16'h0000;
    end else begin
      bus_pin_out[7:0] <= bus_addr_phase ? bus_address[7:0]
                                         : bus_write_data[7:0];
      bus_pin_oe[7:0]  <= {8{~bus_released
                          & (bus_addr_phase | bus_data_drive)}};
      if (strap_r == STRAP_MUX16) begin
        bus_pin_out[15:8] <= bus_addr_phase ? bus_address[15:8]
                                            : bus_write_data[15:8];
        bus_pin_oe[15:8]  <= {8{~bus_released
                             & (bus_addr_phase | bus_data_drive)}};
      end else begin
        bus_pin_out[15:8] <= bus_address[15:8];
        bus_pin_oe[15:8]  <= {8{~bus_released}};
      end
      bus_pin_out[23:16] <= bus_address[23:16];
      bus_pin_oe[23:16]  <= {8{~bus_released}};
      bus_read_data[7:0] <= bus_pin_in[7:0];
      bus_read_data[15:8] <= (strap_r == STRAP_MUX16)
                           ? bus_pin_in[15:8] : 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  plain_output_a: assert property (
    port8_direction_reg[7] |=> port8_pin_oe[7]
      && port8_pin_out[7] == $past(port8_output_latch[7]))
    else $error("Plain output pin not driving latch value.");
  osc_open_drain_a: assert property (
    port9_pin_oe[7:6] != 2'b00 |-> port9_pin_out[7:6] == 2'b00)
    else $error("Oscillator pin driven high.");
  osc_drive_low_a: assert property (
    (port9_direction_reg[6] && !port9_output_latch[6]) |=> port9_pin_oe[6])
    else $error("Oscillator output not pulling low.");
  int_deliver_a: assert property (
    (!porta_direction_reg[0] && porta_pin_in[0]) |=> porta_interrupt_req[0])
    else $error("Interrupt request not delivered.");
  sda_output_a: assert property (
    (porta_direction_reg[6] && porta_function_reg[6] && !od_sel_r[0])
      |=> porta_pin_oe[6] && porta_pin_out[6] == $past(sbus_data_out))
    else $error("Serial data output not driven.");
  open_drain_a: assert property (
    (porta_direction_reg[7] && porta_function_reg[7] && od_sel_r[1]
      && sbus_scl_out) |=> !porta_pin_oe[7])
    else $error("Open-drain pin drives high.");
  od_reset_a: assert property (
    $rose(reset_n) |-> od_sel_r == OD_SEL_RESET)
    else $error("Open-drain select not push-pull after reset.");
  pullup_a: assert property (
    (cs_function_bits[2] && bus_released) |=> chip_select_pullup[2])
    else $error("Chip select pullup not enabled.");
  ad_mux_a: assert property (
    (bus_addr_phase && !bus_released) |=>
      bus_pin_out[7:0] == $past(bus_address[7:0]) && bus_pin_oe[0])
    else $error("Low bus pins missing address.");
  addr_only_a: assert property (
    (strap_r != STRAP_MUX16 && !bus_addr_phase) |=>
      bus_pin_out[15:8] == $past(bus_address[15:8]))
    else $error("Upper byte not address only.");
  high_addr_a: assert property (
    !bus_released |=> bus_pin_out[23:16] == $past(bus_address[23:16])
      && bus_pin_oe[23:16] == 8'hff)
    else $error("Top address pins wrong.");
  capture_a: assert property (
    (port8_pin_in[0] && !port8_direction_reg[0] && !port8_function_reg[0])
      |=> !timer_capture_input[0] && external_interrupt_input[0])
    else $error("Capture input gating wrong.");
  uart_tx_a: assert property (
    (port9_direction_reg[0] && port9_function_reg[0]) |=>
      port9_pin_out[0] == $past(uart_transmit_pin[0]))
    else $error("Transmit output not selected.");

endmodule : port_pin_function_select

// *** tb/pad_partner_model.sv ***
// Behavioural model of the pads and board devices behind one port.
// Assumes device outputs change only after rising clock edges.
module pad_partner_model #(
  parameter int           W    = 8,
  parameter logic [W-1:0] PULL = '0
) (
  // Clock.
  input  wire logic         clk,
  // Device drive and the far side's own drive.
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  // Resolved pin level seen by the device.
  output logic      [W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Level of each pin in the previous cycle.
  logic [W-1:0] last_r = '0;

  // A floating pin keeps no value: it flips every cycle, so that a design
  // reading a released line can never match by luck.
  always @(posedge clk) begin
    last_r <= pin_in;
  end

  // The device wins, then the board driver, then any pull-up resistor.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = dev_oe[i] ? dev_out[i] : ext_en[i] ? ext_val[i] :
                  PULL[i] ? 1'b1 : ~last_r[i];
    end
  end
endmodule : pad_partner_model

// *** tb/port_pin_function_select_tb_top.sv ***
// Self-checking bench for the pin function selection block.
// Assumes the package, the design and the pad model are compiled first.
module port_pin_function_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_select_pkg::*;
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk, reset_n, sbus_sck_out, sbus_data_out, sbus_scl_out;
  logic [7:0]  port8_direction_reg, port8_function_reg, port8_output_latch;
  logic [7:0]  port8_pin_in, port8_pin_out, port8_pin_oe, port8_read;
  logic [2:0]  timer_flipflop_output;
  logic [3:0]  timer_capture_input, external_interrupt_input;
  logic [7:0]  port9_direction_reg, port9_output_latch, port9_pin_in;
  logic [5:0]  port9_function_reg;
  logic [7:0]  port9_pin_out, port9_pin_oe, port9_read;
  logic [1:0]  uart_transmit_pin, uart_clock_pin;
  logic [1:0]  uart_receive_pin, uart_clear_to_send_pin;
  logic [7:0]  porta_direction_reg, porta_function_reg, porta_output_latch;
  logic [7:0]  porta_pin_in, porta_pin_out, porta_pin_oe, porta_read;
  logic [3:0]  porta_interrupt_req, cs_function_bits, chip_select_pullup;
  logic        sbus_sck_in, sbus_data_in, sbus_scl_in;
  logic        open_drain_select_load, bus_released;
  logic [1:0]  open_drain_select_field, open_drain_enable_reg;
  logic        strobe_function_bit, rw_function_bit;
  logic        high_byte_write_strobe_pullup, rw_indicator_pullup;
  logic        bus_width_strap_pin, bus_addr_phase, bus_data_drive;
  logic [23:0] bus_address, bus_pin_out, bus_pin_oe;
  logic [15:0] bus_write_data, bus_pin_in, bus_read_data;
  // Board drive commanded by the scenarios.
  logic [7:0]  ext8_val, ext8_en, ext9_val, ext9_en, exta_val, exta_en;
  logic [15:0] extb_val, extb_en;
  int          err_count, cmp_count;

  port_pin_function_select dut_u (.*);
  pad_partner_model #(.W(8)) pad8_u (.clk(clk), .dev_out(port8_pin_out),
    .dev_oe(port8_pin_oe), .ext_val(ext8_val), .ext_en(ext8_en),
    .pin_in(port8_pin_in));
  // Open-drain pins 6 and 7 have board pull-ups on both ports.
  pad_partner_model #(.W(8), .PULL(8'hc0)) pad9_u (.clk(clk),
    .dev_out(port9_pin_out), .dev_oe(port9_pin_oe), .ext_val(ext9_val),
    .ext_en(ext9_en), .pin_in(port9_pin_in));
  pad_partner_model #(.W(8), .PULL(8'hc0)) pada_u (.clk(clk),
    .dev_out(porta_pin_out), .dev_oe(porta_pin_oe), .ext_val(exta_val),
    .ext_en(exta_en), .pin_in(porta_pin_in));
  pad_partner_model #(.W(16)) padb_u (.clk(clk),
    .dev_out(bus_pin_out[15:0]), .dev_oe(bus_pin_oe[15:0]),
    .ext_val(extb_val), .ext_en(extb_en), .pin_in(bus_pin_in));

  // ****************************************************************
  // Clock, tasks and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Outputs are registered and pins loop back, so three edges suffice.
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // The strap is sampled only while reset is held.
  task automatic do_reset(input logic strap);
    @(posedge clk);
    reset_n             <= 1'b0;
    bus_width_strap_pin <= strap;
    repeat (3) @(negedge clk);
    `CHK("od reset", OD_SEL_RESET, open_drain_enable_reg)
    `CHK("p8 oe reset", PIN_RESET, port8_pin_oe)
    @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  task automatic bus_step(input logic ap, input logic dd);
    @(posedge clk);
    bus_addr_phase <= ap;
    bus_data_drive <= dd;
    settle;
  endtask : bus_step

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // A hang counts as a mismatch; 1 ms is 40000 cycles.
  initial begin
    #1ms;
    err_count++;
    finish_test;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    err_count = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    {port8_direction_reg, port8_function_reg, port8_output_latch,
     timer_flipflop_output, port9_direction_reg, port9_function_reg,
     port9_output_latch, uart_transmit_pin, uart_clock_pin} = '0;
    {porta_direction_reg, porta_function_reg, porta_output_latch,
     sbus_sck_out, sbus_data_out, sbus_scl_out, open_drain_select_load,
     open_drain_select_field, strobe_function_bit, rw_function_bit,
     cs_function_bits, bus_released, bus_width_strap_pin} = '0;
    {bus_addr_phase, bus_data_drive, bus_address, bus_write_data} = '0;
    {ext8_val, ext8_en, ext9_val, ext9_en, exta_val, exta_en} = '0;
    {extb_val, extb_en} = '0;
    do_reset(STRAP_MUX16);
    // Timer port: alternates ignore the latch, pin 7 follows it.
    @(posedge clk);
    port8_direction_reg   <= 8'he4;
    port8_function_reg    <= 8'h67;
    timer_flipflop_output <= 3'b101;
    ext8_en               <= 8'h1b;
    ext8_val              <= 8'h0b;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      port8_output_latch <= k ? 8'h00 : 8'hff;
      settle;
      `CHK("p8 out", k ? 8'h44 : 8'hc4, port8_pin_out & 8'he4)
      `CHK("p8 oe", 8'he4, port8_pin_oe)
    end
    `CHK("p8 read", 8'h0b, port8_read & 8'h1b)
    `CHK("capture", 4'b0011, timer_capture_input)
    `CHK("p8 irq", 4'b0111, external_interrupt_input)
    // Serial port outputs, receive inputs and open-drain pins 6 and 7.
    @(posedge clk);
    port9_direction_reg <= 8'hed;
    port9_function_reg  <= 6'h2d;
    port9_output_latch  <= 8'h80;
    uart_transmit_pin   <= 2'b10;
    uart_clock_pin      <= 2'b01;
    ext9_en             <= 8'h12;
    ext9_val            <= 8'h10;
    settle;
    `CHK("p9 oe", 8'h6d, port9_pin_oe)
    `CHK("p9 out", 8'h0c, port9_pin_out & 8'h6d)
    `CHK("p9 od read", 8'h80, port9_read & 8'hc0)
    `CHK("rx", 2'b10, uart_receive_pin)
    @(posedge clk);
    // Oscillator pins go back to input, as crystal use requires.
    port9_direction_reg <= 8'h00;
    port9_function_reg  <= 6'h24;
    ext9_en             <= 8'h36;
    ext9_val            <= 8'h20;
    settle;
    `CHK("cts", 2'b10, uart_clear_to_send_pin)
    `CHK("rx idle", 2'b00, uart_receive_pin)
    // Serial-bus port: push-pull outputs after reset, interrupts in.
    @(posedge clk);
    // Pin 4 is a plain output driving its latch beside the serial pins.
    porta_direction_reg <= 8'hf0;
    porta_function_reg  <= 8'he0;
    porta_output_latch  <= 8'h10;
    {sbus_sck_out, sbus_data_out, sbus_scl_out} <= 3'b111;
    exta_en             <= 8'h0f;
    exta_val            <= 8'h05;
    settle;
    `CHK("pa oe", 8'hf0, porta_pin_oe)
    `CHK("pa out", 8'hf0, porta_pin_out & 8'hf0)
    `CHK("pa irq", 4'h5, porta_interrupt_req)
    // Open-drain on the clock line only; it releases a high level.
    @(posedge clk);
    open_drain_select_load  <= 1'b1;
    open_drain_select_field <= 2'b10;
    @(posedge clk);
    open_drain_select_load  <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sbus_scl_out <= k ? 1'b0 : 1'b1;
      settle;
      `CHK("od field", 2'b10, open_drain_enable_reg)
      `CHK("pa od oe", k ? 8'he0 : 8'h60, porta_pin_oe & 8'he0)
      `CHK("pa od out", 8'h70, porta_pin_out & porta_pin_oe)
    end
    // Inputs, with wake-up function bits set on the interrupt pins.
    @(posedge clk);
    porta_direction_reg <= 8'h00;
    porta_function_reg  <= 8'h2f;
    exta_en             <= 8'hef;
    exta_val            <= 8'h65;
    settle;
    `CHK("sbus in", 3'b011, {sbus_scl_in, sbus_data_in, sbus_sck_in})
    `CHK("pa irq wake", 4'h5, porta_interrupt_req)
    // Pin 4 floats here, so it is left out of the read-back.
    `CHK("pa read", 8'h65, porta_read & 8'hef)
    // Pull-ups follow function bits only while the bus is released.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      strobe_function_bit <= 1'b1;
      rw_function_bit     <= 1'b1;
      cs_function_bits    <= 4'ha;
      bus_released        <= k[0];
      settle;
      `CHK("strobe pu", k[0], high_byte_write_strobe_pullup)
      `CHK("rw pu", k[0], rw_indicator_pullup)
      `CHK("cs pu", k ? 4'ha : 4'h0, chip_select_pullup)
    end
    // External bus: address, write data and read data on both straps.
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        do_reset(~STRAP_MUX16);
      end
      @(posedge clk);
      bus_released   <= 1'b0;
      bus_address    <= 24'h5a3c96;
      bus_write_data <= 16'hc3e1;
      extb_en        <= 16'h0000;
      bus_step(1'b1, 1'b0);
      `CHK("addr", 24'h5a3c96, bus_pin_out)
      `CHK("addr oe", 24'hffffff, bus_pin_oe)
      bus_step(1'b0, 1'b1);
      `CHK("wdata", s ? 24'h5a3ce1 : 24'h5ac3e1, bus_pin_out)
      @(posedge clk);
      extb_en  <= 16'hffff;
      extb_val <= 16'h9e71;
      bus_step(1'b0, 1'b0);
      `CHK("rdata", s ? 16'h0071 : 16'h9e71, bus_read_data)
      `CHK("hi addr", 8'h5a, bus_pin_out[23:16])
    end
    finish_test;
  end
endmodule : port_pin_function_select_tb_top
